// *** rtl/infrared_tx_and_learning.sv ***
// Infrared transmitter with descriptor FIFO, carrier, and learning receiver
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Output is either carrier modulated or plain on/off, set by a control bit.
// - With modulation on, carrier is gated onto every on interval of output.
// - On/off source is descriptor FIFO, a software bit, or UART serial output.
// - Descriptor holds a level and a 1 to 32767 microsecond duration.
// - Descriptors are queued in a FIFO and played back to back without gaps.
// - Learning receiver accepts modulated and unmodulated input, reports activity.
// - Modulated input carriers from 10 kHz up to 500 kHz are detected, measured.
// - Length of each present and each absent interval is measured and reported.
module infrared_tx_and_learning #(
  parameter int FIFO_DEPTH      = 8,
  parameter int CAR_HOLD        = irtx_pkg::CAR_HOLD_CYCLES
) (
  input  wire logic        mclk_i,
  input  wire logic        sys_rst_i,
  input  wire logic [7:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  input  wire logic [7:0]  s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  input  wire logic        uart_txd_i,
  input  wire logic        infrared_learning_receiver_pin_i,
  output logic             infrared_transmitter_pin_o,
  output logic             irq_o
);
  import irtx_pkg::*;

  localparam int AW = $clog2(FIFO_DEPTH);

  // Register file and bus handshake state
  logic [6:0]       ctrl_q;
  logic [15:0]      car_half_q;
  logic [ST_W-1:0]  status_q, status_d, mask_q;
  logic             awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0]       bresp_q, rresp_q;
  logic [31:0]      rdata_q;
  logic [7:0]       awaddr_q;
  logic [31:0]      wdata_q;
  logic [3:0]       wstrb_q;
  logic             irq_q;

  // Descriptor FIFO, flip-flop storage addressed by index
  logic [15:0]      fifo_mem_q [FIFO_DEPTH];
  logic [AW-1:0]    wr_ptr_q, rd_ptr_q;
  logic [AW:0]      count_q;

  // Playback and output state
  typedef enum logic {PB_IDLE, PB_PLAY} pb_state_type;
  pb_state_type     pb_q;
  logic [DUR_W-1:0] remain_q;
  logic             pb_level_q;
  logic [7:0]       tick_cnt_q;
  logic [15:0]      car_cnt_q;
  logic             carrier_q;
  logic             tx_q;

  // Learning state
  logic             rx_meta_q, rx_sync_q, rx_prev_q;
  logic [15:0]      per_cnt_q;
  logic [15:0]      lcar_q;
  logic [$clog2(CAR_HOLD+1)-1:0] hold_q;
  logic             present_q;
  logic [DUR_W-1:0] len_q;
  logic [15:0]      learn_q;

  // Saturating increment for the learning interval counter
  function automatic logic [DUR_W-1:0] sat_inc(input logic [DUR_W-1:0] v);
    sat_inc = (v == DUR_MAX) ? v : DUR_W'(v + 1'b1);
  endfunction : sat_inc

  // Bus decode and access strobes
  wire wr_go     = !awready_q && !wready_q && !bvalid_q;
  wire wr_ctrl   = wr_go && awaddr_q == CTRL_OFS;
  wire wr_car    = wr_go && awaddr_q == CARRIER_OFS;
  wire wr_desc   = wr_go && awaddr_q == DESC_OFS && wstrb_q[1:0] == 2'h3;
  wire wr_status = wr_go && awaddr_q == STATUS_OFS;
  wire wr_mask   = wr_go && awaddr_q == MASK_OFS;
  wire wr_ok     = awaddr_q == CTRL_OFS || awaddr_q == CARRIER_OFS ||
                   awaddr_q == DESC_OFS || awaddr_q == STATUS_OFS ||
                   awaddr_q == MASK_OFS;
  wire ar_hs     = s_axi_arvalid_i && arready_q;
  wire rd_ok     = s_axi_araddr_i[7:5] == 3'h0 && s_axi_araddr_i[1:0] == 2'h0;

  // Read data selection; unmapped addresses read zero with an error
  logic [31:0] rd_mux;
  always_comb begin
    unique case (s_axi_araddr_i)
      CTRL_OFS:     rd_mux = {25'h0, ctrl_q};
      CARRIER_OFS:  rd_mux = {16'h0, car_half_q};
      DESC_OFS:     rd_mux = 32'h0;
      STATUS_OFS:   rd_mux = {28'h0, status_q};
      MASK_OFS:     rd_mux = {28'h0, mask_q};
      LEARN_OFS:    rd_mux = {16'h0, learn_q};
      LCARRIER_OFS: rd_mux = {16'h0, lcar_q};
      LEVEL_OFS:    rd_mux = {{(31-AW){1'b0}}, count_q};
      default:      rd_mux = 32'h0;
    endcase
  end

  // Control field decode
  source_type src;
  assign src = source_type'(ctrl_q[CTRL_SRC_LSB +: 2]);
  wire  play_en   = ctrl_q[CTRL_PLAY_BIT];
  wire  mod_en    = ctrl_q[CTRL_MOD_BIT];
  wire  learn_en  = ctrl_q[CTRL_LEARN_BIT];
  wire  learn_mod = ctrl_q[CTRL_LMOD_BIT];

  // FIFO flags; a full FIFO drops the write and flags overflow
  wire fifo_empty = count_q == '0;
  wire fifo_full  = count_q == (AW+1)'(FIFO_DEPTH);
  wire push       = wr_desc && !fifo_full;
  wire tick       = tick_cnt_q == 8'(TICK_CYCLES - 1);
  wire need_next  = tick && (pb_q == PB_IDLE || remain_q == DUR_W'(1));
  wire pop        = play_en && src == SRC_FIFO && need_next && !fifo_empty;
  wire [15:0] head = fifo_mem_q[rd_ptr_q];
  // A zero duration would wrap and last 32768 ticks, so it plays as one tick
  wire [DUR_W-1:0] head_dur = (head[DUR_W-1:0] == '0) ? DUR_W'(1)
                                                      : head[DUR_W-1:0];
  wire underrun  = play_en && src == SRC_FIFO && pb_q == PB_PLAY &&
                   tick && remain_q == DUR_W'(1) && fifo_empty;

  // Selected on/off level before the carrier is applied
  logic src_on;
  always_comb begin
    unique case (src)
      SRC_FIFO: src_on = pb_q == PB_PLAY && pb_level_q;
      SRC_BIT:  src_on = ctrl_q[CTRL_SOFT_BIT];
      SRC_UART: src_on = !uart_txd_i;  // Idle-high line means emitter off
      default:  src_on = 1'b0;
    endcase
  end
  wire tx_d = play_en && src_on && (!mod_en || carrier_q);

  // Learning: carrier edge detect on the synchronised pin
  wire rx_rise    = rx_sync_q && !rx_prev_q;
  wire per_in_rng = per_cnt_q >= 16'(CAR_PER_MIN) &&
                    per_cnt_q <= 16'(CAR_PER_MAX);
  wire present_d  = learn_mod ? (hold_q != '0) : rx_sync_q;
  wire edge_seen  = learn_en && present_d != present_q;

  // Sticky status: a hardware set wins over a same-cycle write-one clear
  wire [ST_W-1:0] st_set = {edge_seen && status_q[ST_LEARNED],
                            edge_seen,
                            wr_desc && fifo_full,
                            underrun};
  wire [ST_W-1:0] st_clr = wr_status ? wdata_q[ST_W-1:0] : '0;
  assign status_d = (status_q & ~st_clr) | st_set;

  // Write address and data channels, taken in either order
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h0;
      wstrb_q   <= 4'h0;
    end else begin
      if (s_axi_awvalid_i && awready_q) begin
        awaddr_q  <= s_axi_awaddr_i;
        awready_q <= 1'b0;
      end
      if (s_axi_wvalid_i && wready_q) begin
        wdata_q  <= s_axi_wdata_i;
        wstrb_q  <= s_axi_wstrb_i;
        wready_q <= 1'b0;
      end
      if (wr_go) begin
        bvalid_q <= 1'b1;
        bresp_q  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready_i) begin
        bvalid_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  // Read channel, one read in flight
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0;
      rresp_q   <= RESP_OKAY;
    end else if (ar_hs) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rdata_q   <= rd_ok ? rd_mux : 32'h0;
      rresp_q   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready_i) begin
      rvalid_q  <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  // Software registers and interrupt
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      ctrl_q     <= CTRL_RESET;
      car_half_q <= CARRIER_RESET;
      mask_q     <= '0;
      status_q   <= '0;
      irq_q      <= 1'b0;
    end else begin
      if (wr_ctrl && wstrb_q[0]) ctrl_q <= wdata_q[6:0];
      if (wr_car) car_half_q <= wdata_q[15:0];
      if (wr_mask) mask_q <= wdata_q[ST_W-1:0];
      status_q <= status_d;
      irq_q    <= |(status_d & mask_q);
    end
  end

  // Descriptor FIFO storage and pointers
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else begin
      if (push) begin
        fifo_mem_q[wr_ptr_q] <= wdata_q[15:0];
        wr_ptr_q <= (wr_ptr_q == AW'(FIFO_DEPTH - 1)) ? '0
                                                      : AW'(wr_ptr_q + 1'b1);
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == AW'(FIFO_DEPTH - 1)) ? '0
                                                      : AW'(rd_ptr_q + 1'b1);
      end
      count_q <= (AW+1)'(count_q + push - pop);
    end
  end

  // Microsecond tick shared by playback and learning
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) tick_cnt_q <= 8'h00;
    else           tick_cnt_q <= tick ? 8'h00 : 8'(tick_cnt_q + 1'b1);
  end

  // Playback: next descriptor loads on the tick that ends the current one,
  // so consecutive descriptors meet without a gap
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      pb_q       <= PB_IDLE;
      remain_q   <= '0;
      pb_level_q <= 1'b0;
    end else if (!play_en || src != SRC_FIFO) begin
      pb_q       <= PB_IDLE;
      pb_level_q <= 1'b0;
    end else if (pop) begin
      pb_q       <= PB_PLAY;
      remain_q   <= head_dur;
      pb_level_q <= head[DESC_LEVEL_BIT];
    end else if (underrun) begin
      pb_q       <= PB_IDLE;
      pb_level_q <= 1'b0;
    end else if (pb_q == PB_PLAY && tick) begin
      remain_q <= DUR_W'(remain_q - 1'b1);
    end
  end

  // Carrier generator: toggles every half period; zero acts as one
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      car_cnt_q <= 16'h0000;
      carrier_q <= 1'b0;
      tx_q      <= 1'b0;
    end else begin
      if (car_cnt_q + 16'h0001 >= car_half_q) begin
        car_cnt_q <= 16'h0000;
        carrier_q <= !carrier_q;
      end else begin
        car_cnt_q <= car_cnt_q + 16'h0001;
      end
      tx_q <= tx_d;
    end
  end

  // Receive pin synchroniser; the second stage feeds logic, and the third stage delays it for edge detect
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      rx_meta_q <= 1'b0;
      rx_sync_q <= 1'b0;
      rx_prev_q <= 1'b0;
    end else begin
      rx_meta_q <= infrared_learning_receiver_pin_i;
      rx_sync_q <= rx_meta_q;
      rx_prev_q <= rx_sync_q;
    end
  end

  // Carrier measurement: period between rising edges, kept when in band;
  // presence holds for two of the slowest periods after an in-band edge
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      per_cnt_q <= 16'h0000;
      lcar_q    <= 16'h0000;
      hold_q    <= '0;
    end else begin
      if (rx_rise) begin
        per_cnt_q <= 16'h0001;
        if (per_in_rng) begin
          lcar_q <= per_cnt_q;
          hold_q <= ($bits(hold_q))'(CAR_HOLD);
        end
      end else begin
        if (per_cnt_q != 16'hFFFF) per_cnt_q <= per_cnt_q + 16'h0001;
        if (hold_q != '0) hold_q <= hold_q - 1'b1;
      end
    end
  end

  // Interval measurement: each present or absent span in microseconds.
  // Result holds the level of the span just ended and its length.
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      present_q <= 1'b0;
      len_q     <= '0;
      learn_q   <= 16'h0000;
    end else if (!learn_en) begin
      present_q <= present_d;
      len_q     <= '0;
    end else if (edge_seen) begin
      present_q <= present_d;
      learn_q   <= {present_q, len_q};
      len_q     <= '0;
    end else if (tick) begin
      len_q <= sat_inc(len_q);
    end
  end

  // Outputs straight from flip-flops
  assign s_axi_awready_o = awready_q;
  assign s_axi_wready_o  = wready_q;
  assign s_axi_bvalid_o  = bvalid_q;
  assign s_axi_bresp_o   = bresp_q;
  assign s_axi_arready_o = arready_q;
  assign s_axi_rvalid_o  = rvalid_q;
  assign s_axi_rdata_o   = rdata_q;
  assign s_axi_rresp_o   = rresp_q;
  assign infrared_transmitter_pin_o     = tx_q;
  assign irq_o           = irq_q;

endmodule : infrared_tx_and_learning

`default_nettype wire

// *** rtl/irtx_pkg.sv ***
// Shared constants for the infrared transmitter and learning receiver block
package irtx_pkg;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS      = 8'h00;
  localparam logic [7:0] CARRIER_OFS   = 8'h04;
  localparam logic [7:0] DESC_OFS      = 8'h08;
  localparam logic [7:0] STATUS_OFS    = 8'h0C;
  localparam logic [7:0] MASK_OFS      = 8'h10;
  localparam logic [7:0] LEARN_OFS     = 8'h14;
  localparam logic [7:0] LCARRIER_OFS  = 8'h18;
  localparam logic [7:0] LEVEL_OFS     = 8'h1C;

  // Control register fields
  localparam int CTRL_PLAY_BIT  = 0;
  localparam int CTRL_SRC_LSB   = 1;
  localparam int CTRL_MOD_BIT   = 3;
  localparam int CTRL_SOFT_BIT  = 4;
  localparam int CTRL_LEARN_BIT = 5;
  localparam int CTRL_LMOD_BIT  = 6;
  localparam logic [6:0] CTRL_RESET = 7'h00;

  // Carrier half period in clock cycles
  localparam logic [15:0] CARRIER_RESET = 16'h0064;

  // Descriptor fields: level on top, duration in microseconds below
  localparam int DESC_LEVEL_BIT = 15;
  localparam int DUR_W          = 15;
  localparam logic [DUR_W-1:0] DUR_MAX = 15'h7FFF;

  // Sticky status bits
  localparam int ST_UNDERRUN = 0;
  localparam int ST_OVERFLOW = 1;
  localparam int ST_LEARNED  = 2;
  localparam int ST_LOST     = 3;
  localparam int ST_W        = 4;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Timing: clock rate, microsecond tick, learning carrier window
  localparam int CLK_HZ          = 200_000_000;
  localparam int TICK_US         = 1;
  localparam int TICK_CYCLES     = CLK_HZ / 1_000_000 * TICK_US;
  localparam int CARRIER_MIN_HZ  = 10_000;
  localparam int CARRIER_MAX_HZ  = 500_000;
  localparam int CAR_PER_MAX     = CLK_HZ / CARRIER_MIN_HZ;
  localparam int CAR_PER_MIN     = (CLK_HZ + CARRIER_MAX_HZ - 1) / CARRIER_MAX_HZ;
  localparam int CAR_HOLD_CYCLES = 2 * CAR_PER_MAX;

  // Source of the on/off pattern
  typedef enum logic [1:0] {
    SRC_FIFO = 2'h0,
    SRC_BIT  = 2'h1,
    SRC_UART = 2'h2
  } source_type;

endpackage : irtx_pkg

// *** dv/infrared_tx_and_learning_checker.sv ***
// Port-level checks for the infrared transmitter and learning block
`timescale 1ns/1ps
`default_nettype none
module infrared_tx_and_learning_checker #(
  parameter int FIFO_DEPTH = 8,
  parameter int CAR_HOLD   = 2000
) (
  input wire logic        mclk_i,
  input wire logic        sys_rst_i,
  input wire logic        s_axi_awvalid_i,
  input wire logic        s_axi_awready_o,
  input wire logic        s_axi_wvalid_i,
  input wire logic        s_axi_wready_o,
  input wire logic [1:0]  s_axi_bresp_o,
  input wire logic        s_axi_bvalid_o,
  input wire logic        s_axi_bready_i,
  input wire logic        s_axi_arvalid_i,
  input wire logic        s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic [1:0]  s_axi_rresp_o,
  input wire logic        s_axi_rvalid_o,
  input wire logic        s_axi_rready_i,
  input wire logic        infrared_transmitter_pin_o,
  input wire logic        irq_o
);
  import irtx_pkg::*;
  // One clock domain, so clock and reset are given once
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);

  // Response is registered after a strobe cycle, so it shows two edges on
  a_write_answer: assert property (
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
    |-> ##2 s_axi_bvalid_o)
    else $error("write answer missing");
  a_bresp_stands: assert property (
    s_axi_bvalid_o && !s_axi_bready_i
    |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write answer dropped");
  a_read_answer: assert property (
    s_axi_arvalid_i && s_axi_arready_o
    |=> s_axi_rvalid_o && !s_axi_arready_o)
    else $error("read answer missing");
  a_rdata_stands: assert property (
    s_axi_rvalid_o && !s_axi_rready_i
    |=> s_axi_rvalid_o && $stable(s_axi_rdata_o) && $stable(s_axi_rresp_o))
    else $error("read answer changed");
  a_write_blocked: assert property (
    s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
    else $error("write taken while answer pending");
  a_ready_return: assert property (
    s_axi_bvalid_o && s_axi_bready_i
    |=> s_axi_awready_o && s_axi_wready_o)
    else $error("write slot not freed");
  a_error_zero: assert property (
    s_axi_rvalid_o && s_axi_rresp_o == RESP_SLVERR
    |-> s_axi_rdata_o == 32'h0)
    else $error("refused read returned data");
  a_reset_quiet: assert property (
    $fell(sys_rst_i)
    |-> !infrared_transmitter_pin_o && !irq_o && !s_axi_bvalid_o && !s_axi_rvalid_o)
    else $error("outputs not idle after reset");

  // Main scenarios seen at the ports
  c_write: cover property (s_axi_bvalid_o && s_axi_bready_i);
  c_refused: cover property (s_axi_rvalid_o && s_axi_rresp_o == RESP_SLVERR);
  c_irq: cover property ($rose(irq_o));
  c_emit: cover property ($rose(infrared_transmitter_pin_o));
endmodule : infrared_tx_and_learning_checker

bind infrared_tx_and_learning infrared_tx_and_learning_checker #(
  .FIFO_DEPTH(FIFO_DEPTH), .CAR_HOLD(CAR_HOLD)) chk_u (
  .mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
  .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
  .s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wready_o(s_axi_wready_o),
  .s_axi_bresp_o(s_axi_bresp_o), .s_axi_bvalid_o(s_axi_bvalid_o),
  .s_axi_bready_i(s_axi_bready_i), .s_axi_arvalid_i(s_axi_arvalid_i),
  .s_axi_arready_o(s_axi_arready_o), .s_axi_rdata_o(s_axi_rdata_o),
  .s_axi_rresp_o(s_axi_rresp_o), .s_axi_rvalid_o(s_axi_rvalid_o),
  .s_axi_rready_i(s_axi_rready_i), .infrared_transmitter_pin_o(infrared_transmitter_pin_o), .irq_o(irq_o));
`default_nettype wire

// *** dv/ir_optics.sv ***
// Model of the emitter driver and photodiode receiver on the pin side
`timescale 1ns/1ps
`default_nettype none
module ir_optics (
  input wire logic mclk_i,
  input wire logic tx_pin_i,
  input wire logic clr_i,
  input wire logic present_i,
  input wire logic carrier_i,
  input var int    half_i,
  output logic     rx_pin_o,
  output int       on_cycles_o,
  output int       rises_o
);
  int   ph;
  logic car_q;
  logic tx_q;
  // Carrier of half_i cycles per half, restarting low with each burst
  always_ff @(posedge mclk_i) begin
    if (!present_i || ph >= half_i - 1) ph <= 0;
    else ph <= ph + 1;
    if (!present_i) car_q <= 1'b0;
    else if (ph >= half_i - 1) car_q <= !car_q;
  end
  // Dark receiver reads low, so an absent signal never shows a stale level
  assign rx_pin_o = present_i && (carrier_i ? car_q : 1'b1);
  // Emitter light meter: lit cycles and flashes
  always_ff @(posedge mclk_i) begin
    tx_q <= tx_pin_i;
    on_cycles_o <= clr_i ? 0 : on_cycles_o + int'(tx_pin_i);
    rises_o <= clr_i ? 0 : rises_o + int'(tx_pin_i && !tx_q);
  end
endmodule : ir_optics
`default_nettype wire

// *** dv/test_infrared_tx_and_learning.sv ***
// Self-checking bench for the infrared transmitter and learning block
`timescale 1ns/1ps
`default_nettype none
module test_infrared_tx_and_learning;
  import irtx_pkg::*;
  logic clk, rst, awv, wv, bry, arv, rry, uart, pres, carm, clr;
  logic [7:0] awa, ara;
  logic [31:0] wd, rd;
  logic [1:0] rsp;
  wire logic awr, wr_o, bv, arr, rv, tx, irq, rxp;
  wire logic [1:0] br, rr;
  wire logic [31:0] rdo;
  int fails, checks_done, half, oncyc, rises;
  int dur [3];
  logic [31:0] dq [9];
  int hv [3];

  infrared_tx_and_learning #(.FIFO_DEPTH(8), .CAR_HOLD(2000)) dut_u (
    .mclk_i(clk), .sys_rst_i(rst), .s_axi_awaddr_i(awa),
    .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd),
    .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv), .s_axi_wready_o(wr_o),
    .s_axi_bresp_o(br), .s_axi_bvalid_o(bv), .s_axi_bready_i(bry),
    .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
    .s_axi_rdata_o(rdo), .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv),
    .s_axi_rready_i(rry), .uart_txd_i(uart), .infrared_learning_receiver_pin_i(rxp),
    .infrared_transmitter_pin_o(tx), .irq_o(irq));
  ir_optics opt_u (.mclk_i(clk), .tx_pin_i(tx), .clr_i(clr),
    .present_i(pres), .carrier_i(carm), .half_i(half), .rx_pin_o(rxp),
    .on_cycles_o(oncyc), .rises_o(rises));

  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = !clk;
  end

  task automatic chk(input string nm, input logic [31:0] e, g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic rng(input string nm, input int lo, hi, g);
    checks_done++;
    if (g < lo || g > hi) begin
      fails++;
      $display("Error %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask : rng

  // Write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic ah, wh, bh;
    @(posedge clk);
    awa <= a; wd <= v; awv <= 1'b1; wv <= 1'b1; bry <= 1'b1;
    forever begin
      @(negedge clk);
      ah = awv && awr; wh = wv && wr_o; bh = bv; rsp = br;
      @(posedge clk);
      if (ah) awv <= 1'b0;
      if (wh) wv <= 1'b0;
      if (bh) begin
        bry <= 1'b0;
        break;
      end
    end
  endtask : wr

  task automatic rdr(input logic [7:0] a, output logic [31:0] v);
    logic ah, h;
    @(posedge clk);
    ara <= a; arv <= 1'b1; rry <= 1'b1;
    forever begin
      @(negedge clk);
      ah = arv && arr; h = rv; v = rdo; rsp = rr;
      @(posedge clk);
      if (ah) arv <= 1'b0;
      if (h) begin
        rry <= 1'b0;
        break;
      end
    end
  endtask : rdr

  // Clear the light meter, let n cycles pass, stop at a quiet point
  task automatic meter(input int n);
    @(posedge clk) clr <= 1'b1;
    @(posedge clk) clr <= 1'b0;
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : meter

  task automatic finish_test;
    $display("Checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : finish_test

  // Main sequence
  initial begin
    {awv, wv, bry, arv, rry, pres, carm, clr, awa, ara, wd} = '0;
    uart = 1'b1; half = 1; rst = 1'b1; fails = 0; checks_done = 0;
    void'($urandom(32'h6292));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rdr(CTRL_OFS, rd); chk("ctrl reset", 32'h0, rd);
    rdr(CARRIER_OFS, rd); chk("carrier reset", 32'h64, rd);
    rdr(MASK_OFS, rd); chk("mask reset", 32'h0, rd);
    rdr(8'h20, rd); chk("unmapped resp", RESP_SLVERR, rsp);
    wr(LEARN_OFS, 32'h1); chk("ro write resp", RESP_SLVERR, rsp);
    $display("Test registers done");
    wr(CTRL_OFS, 32'h05);
    repeat (8) begin
      @(posedge clk) uart <= 1'($urandom);
      meter(4); chk("uart drive", !uart, tx);
    end
    wr(CARRIER_OFS, 32'h0A); wr(CTRL_OFS, 32'h1B);
    meter(400); rng("carrier flashes", 19, 21, rises);
    rng("carrier lit", 190, 210, oncyc);
    wr(CTRL_OFS, 32'h13);
    meter(400); rng("plain lit", 395, 402, oncyc);
    wr(CTRL_OFS, 32'h0);
    $display("Test sources done");
    dur[0] = 1;
    dur[1] = $urandom_range(1, 3);
    dur[2] = $urandom_range(1, 3);
    foreach (dq[i]) dq[i] = (i < 3) ? 32'(dur[i]) : 32'h1;
    dq[0] |= 32'h8000; dq[2] |= 32'h8000; dq[8] = 32'h8001;
    foreach (dq[i]) wr(DESC_OFS, dq[i]);
    rdr(LEVEL_OFS, rd); chk("fifo level", 32'h8, rd);
    rdr(STATUS_OFS, rd); chk("overflow flag", 32'h2, rd);
    chk("irq masked", 1'b0, irq);
    wr(STATUS_OFS, 32'h2); wr(MASK_OFS, 32'h1);
    meter(0); wr(CTRL_OFS, 32'h1);
    repeat (100) begin
      rdr(STATUS_OFS, rd);
      if (rd[0]) break;
      repeat (50) @(posedge clk);
    end
    chk("underrun flag", 32'h1, rd);
    chk("lit time", 32'((dur[0] + dur[2]) * 200), oncyc);
    @(negedge clk); chk("irq raised", 1'b1, irq);
    chk("tx off", 1'b0, tx);
    wr(STATUS_OFS, 32'h1); meter(2); chk("irq cleared", 1'b0, irq);
    $display("Test playback done");
    wr(CTRL_OFS, 32'h20);
    @(posedge clk) pres <= 1'b1;
    repeat (1000) @(posedge clk);
    pres <= 1'b0;
    repeat (300) @(posedge clk);
    rdr(LEARN_OFS, rd); chk("learned level", 1'b1, rd[15]);
    rng("learned length", 4, 6, int'(rd[14:0]));
    dur[0] = int'(rd[14:0]);
    rdr(STATUS_OFS, rd); chk("learn flags", 2'h3, rd[3:2]);
    // Replay the learned span as one lit descriptor, as firmware would
    wr(DESC_OFS, 32'h8000 | 32'(dur[0]));
    meter(0);
    wr(CTRL_OFS, 32'h1);
    repeat ((dur[0] + 2) * 200) @(posedge clk);
    @(negedge clk);
    chk("replay lit", 32'(dur[0] * 200), oncyc);
    wr(STATUS_OFS, 32'hD); wr(CTRL_OFS, 32'h60);
    hv = '{200, 10000, $urandom_range(200, 3000)};
    foreach (hv[i]) begin
      @(posedge clk) carm <= 1'b1;
      half <= hv[i]; pres <= 1'b1;
      repeat (4 * hv[i] + 20) @(posedge clk);
      pres <= 1'b0;
      repeat (2100) @(posedge clk);
      rdr(LCARRIER_OFS, rd); chk("carrier period", 32'(2 * hv[i]), rd);
    end
    $display("Test learning done");
    finish_test();
  end

  // Cuts the run short if a wait hangs
  initial begin
    repeat (95000) @(posedge clk);
    fails++;
    finish_test();
  end
endmodule : test_infrared_tx_and_learning
`default_nettype wire
